// >>> sim/fcbat_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none

module fcbat_regs_tb;
	logic ref_clk;
	logic sys_rst;
	fcbat_pkg::fcbat_wb_req_type wb_i;
	fcbat_pkg::fcbat_wb_rsp_type wb_o;
	fcbat_pkg::fcbat_taps_type chan_b_own_taps;
	fcbat_pkg::fcbat_taps_type chan_a_taps;
	fcbat_pkg::fcbat_taps_type combined_taps;
	fcbat_pkg::fcbat_taps_type chan_b_taps;
	fcbat_pkg::fcbat_ctrl_type ctrl;
	logic [31:0] seed;
	logic [31:0] exp_q[$];
	logic [15:0] model [4];
	logic [7:0] c;
	int fail_count;
	int n_tests;

	fcbat_regs i_dut (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.wb_i(wb_i),
		.wb_o(wb_o),
		.chan_b_own_taps(chan_b_own_taps),
		.chan_a_taps(chan_a_taps),
		.combined_taps(combined_taps),
		.chan_b_taps(chan_b_taps),
		.ctrl(ctrl)
	);

	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic [15:0] adr(input logic [11:0] idx);
		return {2'b00, idx, 2'b00};
	endfunction

	task automatic chk(input string name, input logic [71:0] e,
		input logic [71:0] got);
		n_tests++;
		if (got !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", name, e, got);
			fail_count++;
		end
	endtask

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// master waits on ack only; the count n is never checked, a dead slave is caught by the 5000-cycle timeout
	task automatic bus(input logic we, input logic [15:0] a,
		input logic [3:0] sel, input logic [31:0] dat);
		int n;
		@(posedge ref_clk);
		wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: sel, dat: dat};
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (wb_o.ack !== 1'b1);
		chk("ack", 72'h1, wb_o.ack);
		wb_i.cyc <= 1'b0;
		wb_i.stb <= 1'b0;
		@(negedge ref_clk);
	endtask

	task automatic rd(input logic [15:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 4'hf, seed);
	endtask

	task automatic wt(input int i, input logic [3:0] sel,
		input logic [15:0] v);
		if (sel[0]) model[i][7:0] = v[7:0];
		if (sel[1]) model[i][15:8] = v[15:8];
		bus(1'b1, adr(fcbat_pkg::tap_idx[i]), sel, {16'h0000, v});
	endtask

	task automatic tapchk(input int i);
		logic [17:0] e;
		e = {{fcbat_pkg::ext_w{model[i][11]}}, model[i][11:0]};
		chk("chan_a_taps", e, chan_a_taps[i]);
		chk("combined_taps", e, combined_taps[i]);
		rd(adr(fcbat_pkg::tap_idx[i]), model[i] & fcbat_pkg::rd_mask);
	endtask

	// results are matched to the oldest pending read in issue order
	always @(posedge ref_clk) begin
		if (wb_o.ack === 1'b1 && wb_i.we === 1'b0) begin
			if (exp_q.size() == 0) chk("read count", 72'h1, 72'h0);
			else chk("read data", exp_q.pop_front(), wb_o.dat);
		end
	end

	initial begin
		repeat (5000) @(posedge ref_clk);
		fail_count++;
		finish_test();
	end

	initial begin
		sys_rst = 1'b1;
		wb_i = '0;
		chan_b_own_taps = '0;
		seed = 32'h5250;
		fail_count = 0;
		n_tests = 0;
		foreach (model[i]) model[i] = 16'h0000;
		repeat (6) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(negedge ref_clk);
		for (int i = 0; i < 4; i++) tapchk(i);
		rd(adr(fcbat_pkg::idx_cfg), 32'h0);
		rd(adr(fcbat_pkg::idx_link), 32'h0);
		// coefficients only touched while the link is off
		for (int r = 0; r < 3; r++) begin
			for (int i = 0; i < 4; i++) begin
				seed = lfsr(seed);
				if (r == 0 && i < 2) wt(i, 4'h3, i ? 16'h07ff : 16'hf800);
				else wt(i, 4'h3, seed[15:0]);
			end
			for (int i = 0; i < 4; i++) tapchk(i);
		end
		// lane merge, and a write with no lanes must change nothing
		wt(0, 4'h1, seed[15:0]);
		wt(1, 4'h2, seed[31:16]);
		wt(2, 4'h0, 16'h5a5a);
		// flip only the reserved nibble: taps must not move
		wt(3, 4'h2, {~model[3][15:12], model[3][11:0]});
		for (int i = 0; i < 4; i++) tapchk(i);
		for (int m = 0; m < 4; m++) begin
			seed = lfsr(seed);
			@(posedge ref_clk);
			chan_b_own_taps <= {seed, seed, seed[7:0]};
			// share and merge walk all four combinations, mode follows m, scw from the seed
			c = {1'b1, m[0], m[1], seed[2:0], m[1:0]};
			bus(1'b1, adr(fcbat_pkg::idx_cfg), 4'h1, {24'h0, c});
			chk("enable", m == 2, ctrl.enable);
			chk("merge", c[5], ctrl.merge);
			chk("share", c[6], ctrl.share);
			chk("scw", c[4:2], ctrl.scw);
			@(negedge ref_clk);
			chk("chan_b_taps", m[0] ? chan_a_taps : chan_b_own_taps, chan_b_taps);
			rd(adr(fcbat_pkg::idx_cfg), {24'h0, c});
		end
		bus(1'b1, adr(fcbat_pkg::idx_link), 4'h1, 32'h1);
		chk("link_en", 1'b1, ctrl.link_en);
		rd(adr(fcbat_pkg::idx_link), 32'h1);
		bus(1'b1, adr(fcbat_pkg::idx_link), 4'h1, 32'h0);
		chk("link_en", 1'b0, ctrl.link_en);
		bus(1'b1, 16'h1004, 4'hf, 32'hffffffff);
		rd(16'h1004, 32'h0);
		rd(16'h1062, 32'h0);
		repeat (3) @(negedge ref_clk);
		chk("pending reads", 72'h0, exp_q.size());
		finish_test();
	end
endmodule

`default_nettype wire

// >>> verilog/fcbat_coeff_reg.sv
`timescale 1ns/1ps
`default_nettype none

module fcbat_coeff_reg (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// write side
	input wire logic wr_en,
	input wire logic [fcbat_pkg::reg_w-1:0] wr_data,
	input wire logic [fcbat_pkg::reg_w-1:0] wr_mask,
	// read and filter side
	output logic [fcbat_pkg::reg_w-1:0] rd_value,
	output logic [fcbat_pkg::mult_w-1:0] tap_coeff
);

	typedef struct packed {
		logic [fcbat_pkg::reg_w-1:0] value;
	} fcbat_coeff_state_type;

	fcbat_coeff_state_type st;
	fcbat_coeff_state_type next_st;
	logic [fcbat_pkg::coeff_w-1:0] wr_field;

	always_comb begin
		next_st = st;
		// reserved nibble is stored so software reads back what it wrote
		if (wr_en) begin
			next_st.value = (st.value & ~wr_mask) | (wr_data & wr_mask);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st.value <= fcbat_pkg::coeff_rst;
		end else begin
			st <= next_st;
		end
	end

	always_comb begin
		// readback drops the sign bit, the filter still sees it
		rd_value = st.value & fcbat_pkg::rd_mask;
		// only the low twelve bits reach the multiplier
		tap_coeff = {{fcbat_pkg::ext_w{st.value[fcbat_pkg::coeff_msb]}},
			st.value[fcbat_pkg::coeff_msb:0]};
		wr_field = wr_data[fcbat_pkg::coeff_msb:0];
	end

	chk_read_msb_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
		wr_en && wr_mask[fcbat_pkg::coeff_msb] && wr_data[fcbat_pkg::coeff_msb]
		|=> !rd_value[fcbat_pkg::coeff_msb] && tap_coeff[fcbat_pkg::coeff_msb])
		else $error("coefficient sign bit read back or lost");

	chk_field_signed: assert property (@(posedge ref_clk) disable iff (sys_rst)
		wr_en && wr_mask == fcbat_pkg::full_mask
		|=> $signed(tap_coeff) == $signed($past(wr_field)))
		else $error("tap value is not the signed twelve bit field");

	chk_reserved_inert: assert property (@(posedge ref_clk) disable iff (sys_rst)
		wr_en && (((wr_data ^ st.value) & wr_mask & fcbat_pkg::res_mask) != '0)
		&& (((wr_data ^ st.value) & wr_mask & ~fcbat_pkg::res_mask) == '0)
		|=> $stable(tap_coeff))
		else $error("reserved bits changed the tap value");

	chk_sign_ext: assert property (@(posedge ref_clk) disable iff (sys_rst)
		tap_coeff[fcbat_pkg::mult_w-1:fcbat_pkg::coeff_w]
		== {fcbat_pkg::ext_w{tap_coeff[fcbat_pkg::coeff_msb]}})
		else $error("tap value not sign extended");

endmodule

`default_nettype wire

// >>> verilog/fcbat_pkg.sv
package fcbat_pkg;

	// coefficient and bus geometry
	localparam int coeff_w = 12;
	localparam int reg_w = 16;
	localparam int mult_w = 18;
	localparam int ext_w = mult_w - coeff_w;
	localparam int num_taps = 4;
	localparam int bus_w = 32;
	localparam int sel_w = bus_w / 8;
	localparam int adr_w = 16;
	localparam int idx_w = 12;
	localparam int idx_lsb = 2;
	localparam int idx_msb = 13;
	localparam int cfg_w = 8;
	localparam int coeff_msb = coeff_w - 1;

	// register indices, byte address is four times the index
	localparam logic [idx_w-1:0] idx_cfg = 12'h400;
	localparam logic [idx_w-1:0] idx_link = 12'h402;
	localparam logic [idx_w-1:0] idx_tap1 = 12'h418;
	localparam logic [idx_w-1:0] idx_tap2 = 12'h41a;
	localparam logic [idx_w-1:0] idx_tap3 = 12'h41c;
	localparam logic [idx_w-1:0] idx_tap4 = 12'h41e;
	localparam logic [num_taps-1:0][idx_w-1:0] tap_idx = {
		idx_tap4, idx_tap3, idx_tap2, idx_tap1};

	// configuration register fields
	localparam int mode_lsb = 0;
	localparam int mode_msb = 1;
	localparam int scw_lsb = 2;
	localparam int scw_msb = 4;
	localparam int merge_bit = 5;
	localparam int share_bit = 6;
	localparam int link_bit = 0;
	localparam logic [1:0] mode_off = 2'h0;
	localparam logic [1:0] mode_on = 2'h2;

	// reset values and masks
	localparam logic [cfg_w-1:0] cfg_rst = 8'h00;
	localparam logic link_rst = 1'h0;
	localparam logic [reg_w-1:0] coeff_rst = 16'h0000;
	localparam logic [reg_w-1:0] rd_mask = 16'hf7ff;
	localparam logic [reg_w-1:0] res_mask = 16'hf000;
	localparam logic [reg_w-1:0] full_mask = 16'hffff;
	localparam logic [bus_w-1:0] dat_zero = 32'h00000000;

	typedef logic [num_taps-1:0][mult_w-1:0] fcbat_taps_type;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [adr_w-1:0] adr;
		logic [sel_w-1:0] sel;
		logic [bus_w-1:0] dat;
	} fcbat_wb_req_type;

	typedef struct packed {
		logic ack;
		logic [bus_w-1:0] dat;
	} fcbat_wb_rsp_type;

	typedef enum logic [1:0] {
		bus_idle = 2'b01,
		bus_ack = 2'b10
	} fcbat_bus_state_type;

	typedef struct packed {
		logic enable;
		logic merge;
		logic share;
		logic [2:0] scw;
		logic link_en;
	} fcbat_ctrl_type;

endpackage

// >>> verilog/fcbat_regs.sv
// Contract
// - each coefficient is signed two's complement in bits 11 down to 0
// - dual-channel: the four registers are channel A taps one to four
// - single-channel: same registers are taps one to four, combined filter
// - readback returns the coefficient top bit as zero; stored value kept
// - bits 15 to 12 are reserved read-write, reset zero, no filter effect
// - mode field: 0 disables, 2 enables, 1 and 3 reserved
// - with share set, channel B uses the channel A coefficients
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module fcbat_regs (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// wishbone slave
	input wire fcbat_pkg::fcbat_wb_req_type wb_i,
	output var fcbat_pkg::fcbat_wb_rsp_type wb_o,
	// channel B coefficient set from its own bank
	input wire fcbat_pkg::fcbat_taps_type chan_b_own_taps,
	// taps to the filter datapath
	output var fcbat_pkg::fcbat_taps_type chan_a_taps,
	output var fcbat_pkg::fcbat_taps_type combined_taps,
	output var fcbat_pkg::fcbat_taps_type chan_b_taps,
	// filter controls
	output var fcbat_pkg::fcbat_ctrl_type ctrl
);

	typedef struct packed {
		fcbat_pkg::fcbat_bus_state_type bstate;
		logic [fcbat_pkg::bus_w-1:0] rdata;
		logic [fcbat_pkg::cfg_w-1:0] cfg;
		logic link_en;
		fcbat_pkg::fcbat_taps_type chan_b;
	} fcbat_main_state_type;

	fcbat_main_state_type st;
	fcbat_main_state_type next_st;

	logic [fcbat_pkg::idx_w-1:0] idx;
	logic aligned;
	logic hit_cfg;
	logic hit_link;
	logic [fcbat_pkg::num_taps-1:0] hit_tap;
	logic wr_cycle;
	logic [fcbat_pkg::reg_w-1:0] wr_mask;
	logic [fcbat_pkg::reg_w-1:0] wr_data;
	logic [fcbat_pkg::num_taps-1:0][fcbat_pkg::reg_w-1:0] tap_rd;
	fcbat_pkg::fcbat_taps_type tap_val;

	// address split; anything outside the word-aligned window is unmapped
	always_comb begin
		idx = wb_i.adr[fcbat_pkg::idx_msb:fcbat_pkg::idx_lsb];
		aligned = (wb_i.adr[fcbat_pkg::idx_lsb-1:0] == '0)
			&& (wb_i.adr[fcbat_pkg::adr_w-1:fcbat_pkg::idx_msb+1] == '0);
		hit_cfg = aligned && (idx == fcbat_pkg::idx_cfg);
		hit_link = aligned && (idx == fcbat_pkg::idx_link);
		wr_cycle = (st.bstate == fcbat_pkg::bus_ack)
			&& wb_i.cyc && wb_i.stb && wb_i.we;
		wr_mask = {{8{wb_i.sel[1]}}, {8{wb_i.sel[0]}}};
		wr_data = wb_i.dat[fcbat_pkg::reg_w-1:0];
	end

	// one coefficient register per tap, taken in ascending address order
	genvar gi;
	generate
		for (gi = 0; gi < fcbat_pkg::num_taps; gi++) begin : g_tap
			assign hit_tap[gi] = aligned && (idx == fcbat_pkg::tap_idx[gi]);

			fcbat_coeff_reg u_coeff (
				.ref_clk(ref_clk),
				.sys_rst(sys_rst),
				.wr_en(wr_cycle && hit_tap[gi]),
				.wr_data(wr_data),
				.wr_mask(wr_mask),
				.rd_value(tap_rd[gi]),
				.tap_coeff(tap_val[gi])
			);
		end
	endgenerate

	always_comb begin
		next_st = st;
		case (st.bstate)
			fcbat_pkg::bus_idle: begin
				if (wb_i.cyc && wb_i.stb) begin
					next_st.bstate = fcbat_pkg::bus_ack;
					// read data is captured here and held through the ack
					if (hit_cfg) begin
						next_st.rdata = {{(fcbat_pkg::bus_w-fcbat_pkg::cfg_w){1'b0}},
							st.cfg};
					end else if (hit_link) begin
						next_st.rdata = {{(fcbat_pkg::bus_w-1){1'b0}}, st.link_en};
					end else if (hit_tap[0]) begin
						next_st.rdata = {16'h0000, tap_rd[0]};
					end else if (hit_tap[1]) begin
						next_st.rdata = {16'h0000, tap_rd[1]};
					end else if (hit_tap[2]) begin
						next_st.rdata = {16'h0000, tap_rd[2]};
					end else if (hit_tap[3]) begin
						next_st.rdata = {16'h0000, tap_rd[3]};
					end else begin
						next_st.rdata = fcbat_pkg::dat_zero;
					end
				end
			end
			fcbat_pkg::bus_ack: begin
				// always return to idle, so ack is a single-cycle pulse
				next_st.bstate = fcbat_pkg::bus_idle;
				if (wr_cycle && hit_cfg && wb_i.sel[0]) begin
					next_st.cfg = wb_i.dat[fcbat_pkg::cfg_w-1:0];
				end
				if (wr_cycle && hit_link && wb_i.sel[0]) begin
					next_st.link_en = wb_i.dat[fcbat_pkg::link_bit];
				end
			end
			default: begin
				next_st.bstate = fcbat_pkg::bus_idle;
			end
		endcase
		// registered so channel B switches cleanly on a share change
		if (st.cfg[fcbat_pkg::share_bit]) begin
			next_st.chan_b = tap_val;
		end else begin
			next_st.chan_b = chan_b_own_taps;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st.bstate <= fcbat_pkg::bus_idle;
			st.rdata <= fcbat_pkg::dat_zero;
			st.cfg <= fcbat_pkg::cfg_rst;
			st.link_en <= fcbat_pkg::link_rst;
			st.chan_b <= '0;
		end else begin
			st <= next_st;
		end
	end

	always_comb begin
		wb_o.ack = (st.bstate == fcbat_pkg::bus_ack);
		wb_o.dat = st.rdata;
		// same registers feed both filter arrangements, tap one first
		chan_a_taps = tap_val;
		combined_taps = tap_val;
		chan_b_taps = st.chan_b;
		// reserved mode codes leave the filter off rather than guessing
		ctrl.enable = (st.cfg[fcbat_pkg::mode_msb:fcbat_pkg::mode_lsb]
			== fcbat_pkg::mode_on);
		// merge is trusted as set by software for single-channel use
		ctrl.merge = st.cfg[fcbat_pkg::merge_bit];
		ctrl.share = st.cfg[fcbat_pkg::share_bit];
		ctrl.scw = st.cfg[fcbat_pkg::scw_msb:fcbat_pkg::scw_lsb];
		// no lockout here: changes while the link runs are the user's risk
		ctrl.link_en = st.link_en;
	end

	// checks

	sequence cfg_write;
		wr_cycle && hit_cfg && wb_i.sel[0];
	endsequence

	sequence tap2_write;
		wr_cycle && hit_tap[1] && wb_i.sel[0] && wb_i.sel[1];
	endsequence

	sequence bus_request;
		(st.bstate == fcbat_pkg::bus_idle) && wb_i.cyc && wb_i.stb;
	endsequence

	chk_mode_enable: assert property (@(posedge ref_clk) disable iff (sys_rst)
		cfg_write ##0 (wb_i.dat[fcbat_pkg::mode_msb:fcbat_pkg::mode_lsb]
		== fcbat_pkg::mode_on) |=> ctrl.enable)
		else $error("mode two did not enable the filter");

	chk_mode_disable: assert property (@(posedge ref_clk) disable iff (sys_rst)
		cfg_write ##0 (wb_i.dat[fcbat_pkg::mode_msb:fcbat_pkg::mode_lsb]
		!= fcbat_pkg::mode_on) |=> !ctrl.enable)
		else $error("filter enabled by a mode other than two");

	chk_share_copy: assert property (@(posedge ref_clk) disable iff (sys_rst)
		ctrl.share |=> chan_b_taps == $past(chan_a_taps))
		else $error("shared channel B taps differ from channel A");

	chk_own_b_taps: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!ctrl.share |=> chan_b_taps == $past(chan_b_own_taps))
		else $error("channel B lost its own coefficient set");

	chk_tap_order: assert property (@(posedge ref_clk) disable iff (sys_rst)
		tap2_write |=> chan_a_taps[1][fcbat_pkg::coeff_msb:0]
		== $past(wr_data[fcbat_pkg::coeff_msb:0]))
		else $error("second register did not land on tap two");

	chk_combined_same: assert property (@(posedge ref_clk) disable iff (sys_rst)
		tap2_write |=> combined_taps[1] == chan_a_taps[1])
		else $error("combined filter taps differ from channel A taps");

	chk_read_no_msb: assert property (@(posedge ref_clk) disable iff (sys_rst)
		wb_o.ack && !wb_i.we && (|hit_tap)
		|-> !wb_o.dat[fcbat_pkg::coeff_msb])
		else $error("coefficient top bit returned on read");

	chk_ack_pulse: assert property (@(posedge ref_clk) disable iff (sys_rst)
		bus_request |=> wb_o.ack ##1 !wb_o.ack)
		else $error("ack not a single pulse one cycle after request");

endmodule

`default_nettype wire
